// file: mid_decoder.sv
// Instruction decoder and executor for the 14-bit instruction core
`timescale 1ns/1ps
`default_nettype none
`include "mid_decoder_map.svh"

module mid_decoder #(
   parameter int         CYCLE_CLKS = `MID_CYCLE_CLKS,
   parameter logic [6:0] TMR_ADDR   = 7'h01
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        arst_n,
   // Fetch path
   input  wire logic [13:0] instrWord,
   output logic             fetchStrobe,
   // Data register file
   output logic [6:0]       fileRdAddr,
   input  wire logic [7:0]  fileRdData,
   input  wire logic        fileIsPort,
   input  wire logic [7:0]  portPinData,
   output logic             fileWrEn,
   output logic [6:0]       fileWrAddr,
   output logic [7:0]       fileWrData,
   // Program flow
   output logic             pcLoad,
   output logic [10:0]      pcTarget,
   output logic             callPush,
   output logic             retPop,
   output logic             irqReenable,
   output logic             nopCycle,
   // Core state
   output logic [7:0]       accOut,
   output logic             carryFlag,
   output logic             halfCarryFlag,
   output logic             zeroFlag,
   output logic             watchdogExpiryFlag,
   output logic             sleepEnteredFlag,
   // Timer and power
   input  wire logic        prescalerOnTimer,
   output logic             prescalerClear,
   output logic             sleepReq,
   output logic             watchdogKick
);

   // ==================================================================
   // Parameter checks and phase counter
   localparam int PW = $clog2(CYCLE_CLKS);
   localparam logic [PW-1:0] LAST_PH = PW'(CYCLE_CLKS - 1);
   localparam logic [PW-1:0] EXEC_PH = PW'(CYCLE_CLKS - 2);

   if (CYCLE_CLKS < 3) begin : g_chk
      $error("CYCLE_CLKS must be at least 3");
   end

   logic [PW-1:0]        phaseQ;
   mid_pkg::mid_word_t   instrQ;
   mid_pkg::mid_cyc_t    cycState;
   logic                 twoCycQ;
   logic [7:0]           accQ;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         phaseQ <= '0;
      end else if (phaseQ == LAST_PH) begin
         phaseQ <= '0;
      end else begin
         phaseQ <= phaseQ + PW'(1);
      end
   end

   assign fetchStrobe = (phaseQ == LAST_PH);

   // Word of a discarded slot is still latched but never executed
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         instrQ   <= '0;
         cycState <= mid_pkg::CYC_NOP;
      end else if (fetchStrobe) begin
         instrQ   <= instrWord;
         cycState <= twoCycQ ? mid_pkg::CYC_NOP : mid_pkg::CYC_EXEC;
      end
   end

   assign nopCycle   = (cycState == mid_pkg::CYC_NOP);
   assign fileRdAddr = instrQ[6:0];
   assign accOut     = accQ;

   // ==================================================================
   // Execute
   function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
      logic [4:0] nib;
      logic [8:0] sum;
      nib = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
      sum = {1'b0, a} + {1'b0, b} + {8'h00, cin};
      return {nib[4], sum};
   endfunction

   logic [7:0] opnd;
   logic [7:0] lit;
   logic [2:0] bitIdx;
   logic       dest;
   logic [7:0] res;
   logic [9:0] addR;
   logic       useDest, wrF, wrA, zU, cU, hcU, cN, hcN;
   logic       skip, pcL, push, pop, irq, slp, kick;

   assign opnd   = fileIsPort ? portPinData : fileRdData;
   assign lit    = instrQ[7:0];
   assign bitIdx = instrQ[9:7];
   assign dest   = instrQ[`MID_DEST_BIT];

   always_comb begin
      addR = 10'h000;
      res = opnd;
      useDest = 1'b0;
      wrF = 1'b0;
      wrA = 1'b0;
      zU = 1'b0;
      cU = 1'b0;
      hcU = 1'b0;
      cN = carryFlag;
      hcN = halfCarryFlag;
      skip = 1'b0;
      pcL = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      irq = 1'b0;
      slp = 1'b0;
      kick = 1'b0;
      if (cycState == mid_pkg::CYC_EXEC) begin
         unique case (instrQ[13:12])
            `MID_CLS_BYTE: begin
               unique case (instrQ[11:8])
                  `MID_B_MISC: begin
                     if (dest) begin
                        res = accQ;
                        wrF = 1'b1;
                     end else if (instrQ == `MID_W_RETURN) begin
                        pop = 1'b1;
                     end else if (instrQ == `MID_W_RETIRQ) begin
                        pop = 1'b1;
                        irq = 1'b1;
                     end else if (instrQ == `MID_W_SLEEP) begin
                        slp = 1'b1;
                     end else if (instrQ == `MID_W_KICK) begin
                        kick = 1'b1;
                     end
                  end
                  `MID_B_CLEAR: begin
                     res = 8'h00;
                     useDest = 1'b1;
                     zU = 1'b1;
                  end
                  `MID_B_SUB, `MID_B_ADD: begin
                     addR = (instrQ[11:8] == `MID_B_ADD) ? add8(opnd, accQ, 1'b0)
                                                         : add8(opnd, ~accQ, 1'b1);
                     res = addR[7:0];
                     useDest = 1'b1;
                     {zU, cU, hcU} = 3'b111;
                     {hcN, cN} = addR[9:8];
                  end
                  `MID_B_DEC, `MID_B_DECSKIP: begin
                     res = opnd - 8'h01;
                     useDest = 1'b1;
                     zU = (instrQ[11:8] == `MID_B_DEC);
                     skip = (instrQ[11:8] == `MID_B_DECSKIP) && (res == 8'h00);
                  end
                  `MID_B_INC, `MID_B_INCSKIP: begin
                     res = opnd + 8'h01;
                     useDest = 1'b1;
                     zU = (instrQ[11:8] == `MID_B_INC);
                     skip = (instrQ[11:8] == `MID_B_INCSKIP) && (res == 8'h00);
                  end
                  `MID_B_OR: begin
                     res = accQ | opnd;
                     useDest = 1'b1;
                     zU = 1'b1;
                  end
                  `MID_B_AND: begin
                     res = accQ & opnd;
                     useDest = 1'b1;
                     zU = 1'b1;
                  end
                  `MID_B_XOR: begin
                     res = accQ ^ opnd;
                     useDest = 1'b1;
                     zU = 1'b1;
                  end
                  `MID_B_MOVE, `MID_B_COMP: begin
                     res = (instrQ[11:8] == `MID_B_COMP) ? ~opnd : opnd;
                     useDest = 1'b1;
                     zU = 1'b1;
                  end
                  `MID_B_RRC: begin
                     res = {carryFlag, opnd[7:1]};
                     cN = opnd[0];
                     cU = 1'b1;
                     useDest = 1'b1;
                  end
                  `MID_B_RLC: begin
                     res = {opnd[6:0], carryFlag};
                     cN = opnd[7];
                     cU = 1'b1;
                     useDest = 1'b1;
                  end
                  `MID_B_SWAP: begin
                     res = {opnd[3:0], opnd[7:4]};
                     useDest = 1'b1;
                  end
               endcase
            end
            `MID_CLS_BIT: begin
               unique case (instrQ[11:10])
                  `MID_T_CLR: begin
                     res = opnd & ~(8'h01 << bitIdx);
                     wrF = 1'b1;
                  end
                  `MID_T_SET: begin
                     res = opnd | (8'h01 << bitIdx);
                     wrF = 1'b1;
                  end
                  `MID_T_SKIPCLR: skip = ~opnd[bitIdx];
                  `MID_T_SKIPSET: skip = opnd[bitIdx];
               endcase
            end
            `MID_CLS_FLOW: begin
               pcL = 1'b1;
               push = ~instrQ[`MID_FLOW_CALL];
            end
            `MID_CLS_LIT: begin
               unique casez (instrQ[11:8])
                  `MID_L_LOAD: begin
                     res = lit;
                     wrA = 1'b1;
                  end
                  `MID_L_RETLIT: begin
                     res = lit;
                     wrA = 1'b1;
                     pop = 1'b1;
                  end
                  `MID_L_OR: begin
                     res = accQ | lit;
                     {wrA, zU} = 2'b11;
                  end
                  `MID_L_AND: begin
                     res = accQ & lit;
                     {wrA, zU} = 2'b11;
                  end
                  `MID_L_XOR: begin
                     res = accQ ^ lit;
                     {wrA, zU} = 2'b11;
                  end
                  `MID_L_SUB, `MID_L_ADD: begin
                     addR = instrQ[9] ? add8(lit, accQ, 1'b0) : add8(lit, ~accQ, 1'b1);
                     res = addR[7:0];
                     {wrA, zU, cU, hcU} = 4'b1111;
                     {hcN, cN} = addR[9:8];
                  end
                  default: ;
               endcase
            end
         endcase
         if (useDest) begin
            wrF = dest;
            wrA = ~dest;
         end
      end
   end

   // ==================================================================
   // State updates at the execute edge
   wire execEdge = (phaseQ == EXEC_PH);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         accQ <= `MID_ACC_RST;
      end else if (execEdge && wrA) begin
         accQ <= res;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         carryFlag     <= `MID_FLAG_RST;
         halfCarryFlag <= `MID_FLAG_RST;
         zeroFlag      <= `MID_FLAG_RST;
      end else if (execEdge) begin
         if (cU) carryFlag <= cN;
         if (hcU) halfCarryFlag <= hcN;
         if (zU) zeroFlag <= (res == 8'h00);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         watchdogExpiryFlag <= `MID_FLAG_RST;
         sleepEnteredFlag   <= `MID_FLAG_RST;
      end else if (execEdge && slp) begin
         watchdogExpiryFlag <= `MID_SLEEP_EXP;
         sleepEnteredFlag   <= `MID_SLEEP_ENT;
      end else if (execEdge && kick) begin
         watchdogExpiryFlag <= `MID_KICK_EXP;
         sleepEnteredFlag   <= `MID_KICK_ENT;
      end
   end

   // Strobes stand for exactly the clock after the execute edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {fileWrEn, pcLoad, callPush, retPop, irqReenable} <= 5'h00;
         {prescalerClear, sleepReq, watchdogKick} <= 3'h0;
         fileWrAddr <= 7'h00;
         fileWrData <= 8'h00;
         pcTarget   <= 11'h000;
         twoCycQ    <= 1'b0;
      end else begin
         fileWrEn       <= execEdge && wrF;
         prescalerClear <= execEdge && wrF && prescalerOnTimer
                           && (instrQ[6:0] == TMR_ADDR);
         pcLoad         <= execEdge && pcL;
         callPush       <= execEdge && push;
         retPop         <= execEdge && pop;
         irqReenable    <= execEdge && irq;
         sleepReq       <= execEdge && slp;
         watchdogKick   <= execEdge && kick;
         if (execEdge) begin
            fileWrAddr <= instrQ[6:0];
            fileWrData <= res;
            pcTarget   <= instrQ[10:0];
            twoCycQ    <= skip | pcL | pop;
         end
      end
   end

   // ==================================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_exec;
      execEdge && !nopCycle;
   endsequence
   sequence s_slot;
      !fetchStrobe [*3] ##1 fetchStrobe;
   endsequence

   property p_cycle;
      fetchStrobe |=> s_slot;
   endproperty
   a_cycle: assert property (p_cycle) else $error("instruction cycle not four clocks");

   property p_nop;
      fetchStrobe && twoCycQ |=> nopCycle [*4];
   endproperty
   a_nop: assert property (p_nop) else $error("second cycle not a no-operation");

   property p_nowr;
      execEdge && nopCycle |=> !fileWrEn && !pcLoad && $stable(accQ);
   endproperty
   a_nowr: assert property (p_nowr) else $error("discarded word had an effect");

   property p_skipclr;
      s_exec ##0 (instrQ[13:10] == 4'h6 && !opnd[bitIdx]) |=> twoCycQ;
   endproperty
   a_skipclr: assert property (p_skipclr) else $error("clear test did not skip");

   property p_bitflags;
      s_exec ##0 (instrQ[13:12] == `MID_CLS_BIT)
         |=> $stable(carryFlag) && $stable(zeroFlag) && $stable(halfCarryFlag);
   endproperty
   a_bitflags: assert property (p_bitflags) else $error("bit operation changed a flag");

   property p_flow;
      s_exec ##0 (instrQ[13:12] == `MID_CLS_FLOW) |=> pcLoad && twoCycQ
         && pcTarget == $past(instrQ[10:0]) && callPush == !$past(instrQ[11]);
   endproperty
   a_flow: assert property (p_flow) else $error("call or jump mishandled");

   property p_dest;
      s_exec ##0 (instrQ[13:8] == 6'h07) |=> fileWrEn == $past(dest)
         && (($past(dest)) || accQ == $past(res));
   endproperty
   a_dest: assert property (p_dest) else $error("add result went to wrong place");

   property p_presc;
      fileWrEn && fileWrAddr == TMR_ADDR && $past(prescalerOnTimer) |-> prescalerClear;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler not cleared");

   property p_sleep;
      s_exec ##0 (instrQ == `MID_W_SLEEP)
         |=> sleepReq && sleepEnteredFlag == `MID_SLEEP_ENT && !twoCycQ;
   endproperty
   a_sleep: assert property (p_sleep) else $error("standby entry wrong");

   property p_decskip;
      s_exec ##0 (instrQ[13:8] == 6'h0b) |=> twoCycQ == ($past(opnd) == 8'h01)
         && $stable(zeroFlag);
   endproperty
   a_decskip: assert property (p_decskip) else $error("decrement skip wrong");

endmodule
`default_nettype wire

// file: mid_decoder_map.svh
// Opcode fields, encodings, reset values and timing counts of the instruction decoder
`ifndef MID_DECODER_MAP_SVH
`define MID_DECODER_MAP_SVH

// ==================================================================
// Timing
`define MID_CYCLE_CLKS  4

// ==================================================================
// Instruction classes, bits 13:12
`define MID_CLS_BYTE    2'b00
`define MID_CLS_BIT     2'b01
`define MID_CLS_FLOW    2'b10
`define MID_CLS_LIT     2'b11

// ==================================================================
// Byte operation codes, bits 11:8
`define MID_B_MISC      4'h0
`define MID_B_CLEAR     4'h1
`define MID_B_SUB       4'h2
`define MID_B_DEC       4'h3
`define MID_B_OR        4'h4
`define MID_B_AND       4'h5
`define MID_B_XOR       4'h6
`define MID_B_ADD       4'h7
`define MID_B_MOVE      4'h8
`define MID_B_COMP      4'h9
`define MID_B_INC       4'ha
`define MID_B_DECSKIP   4'hb
`define MID_B_RRC       4'hc
`define MID_B_RLC       4'hd
`define MID_B_SWAP      4'he
`define MID_B_INCSKIP   4'hf

// ==================================================================
// Bit sub-codes, bits 11:10, and literal codes, bits 11:8
`define MID_T_CLR       2'b00
`define MID_T_SET       2'b01
`define MID_T_SKIPCLR   2'b10
`define MID_T_SKIPSET   2'b11
`define MID_L_LOAD      4'b00??
`define MID_L_RETLIT    4'b01??
`define MID_L_OR        4'b1000
`define MID_L_AND       4'b1001
`define MID_L_XOR       4'b1010
`define MID_L_SUB       4'b110?
`define MID_L_ADD       4'b111?

// ==================================================================
// Whole control words
`define MID_W_RETURN    14'h0008
`define MID_W_RETIRQ    14'h0009
`define MID_W_SLEEP     14'h0063
`define MID_W_KICK      14'h0064

// ==================================================================
// Field positions
`define MID_DEST_BIT    7
`define MID_FLOW_CALL   11

// ==================================================================
// Reset values and power flag values
`define MID_ACC_RST     8'h00
`define MID_FLAG_RST    1'b0
`define MID_SLEEP_EXP   1'b0
`define MID_SLEEP_ENT   1'b1
`define MID_KICK_EXP    1'b0
`define MID_KICK_ENT    1'b0

`endif

// file: mid_decoder_tb.sv
// Self-checking bench for the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module mid_decoder_tb;
   typedef struct packed {
      logic [12:0] st;
      logic [16:0] io;
      logic [17:0] fl;
   } mid_exp_t;
   localparam int NDIR = 62;
   localparam int NTOT = 462;
   localparam logic [6:0] TMR = 7'h01;
   localparam logic [6:0] PORT = 7'h06;
   localparam logic [6:0] ADDRS [8] = '{7'h01, 7'h06, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h7f};
   localparam logic [13:0] CTRL [4] = '{14'h0008, 14'h0009, 14'h0063, 14'h0064};

   // ====================
   // Signals
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   mid_pkg::mid_word_t instrWord;
   logic [7:0] portPinData = 8'h00;
   logic prescalerOnTimer = 1'b0;
   logic fetchStrobe, fileIsPort, fileWrEn, pcLoad, callPush, retPop, irqReenable, nopCycle;
   logic carryFlag, halfCarryFlag, zeroFlag, watchdogExpiryFlag, sleepEnteredFlag;
   logic prescalerClear, sleepReq, watchdogKick;
   logic [6:0] fileRdAddr, fileWrAddr;
   logic [7:0] fileRdData, fileWrData, accOut;
   logic [10:0] pcTarget;
   logic [12:0] stNow;
   logic [16:0] ioNow;
   logic [17:0] flNow;
   assign stNow = {accOut, carryFlag, halfCarryFlag, zeroFlag, watchdogExpiryFlag, sleepEnteredFlag};
   assign ioNow = {fileWrEn, prescalerClear, fileWrAddr, fileWrData};
   assign flNow = {pcLoad, callPush, retPop, irqReenable, sleepReq, watchdogKick, nopCycle, pcTarget};

   // Reference state
   logic [7:0] acc, curPins;
   logic [7:0] mem [128];
   logic c, hc, z, wx, sl, discard, curPot, running, seenFetch;
   mid_pkg::mid_word_t curWord;
   logic [31:0] seed = 32'h0000005e;
   logic [31:0] tmp, init;
   mid_exp_t q[$];
   mid_exp_t e, x;
   int idx, gap, failures, n_compared;

   always #2 clk = ~clk;

   mid_decoder mid_decoder_inst (.clk(clk), .arst_n(arst_n), .instrWord(instrWord),
      .fetchStrobe(fetchStrobe), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
      .fileIsPort(fileIsPort), .portPinData(portPinData), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .pcLoad(pcLoad), .pcTarget(pcTarget),
      .callPush(callPush), .retPop(retPop), .irqReenable(irqReenable), .nopCycle(nopCycle),
      .accOut(accOut), .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag),
      .zeroFlag(zeroFlag), .watchdogExpiryFlag(watchdogExpiryFlag),
      .sleepEnteredFlag(sleepEnteredFlag), .prescalerOnTimer(prescalerOnTimer),
      .prescalerClear(prescalerClear), .sleepReq(sleepReq), .watchdogKick(watchdogKick));
   mid_file_model #(.PORT_ADDR(PORT)) mid_file_model_inst (.clk(clk), .fileRdAddr(fileRdAddr),
      .fileRdData(fileRdData), .fileIsPort(fileIsPort), .fileWrEn(fileWrEn),
      .fileWrAddr(fileWrAddr), .fileWrData(fileWrData));

   // ====================
   // Helpers
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Sweep every code, byte and bit codes twice each, then random words on a few hot addresses
   function automatic mid_pkg::mid_word_t gen(input int i);
      logic [31:0] r;
      logic [6:0] a;
      r = rnd();
      a = ADDRS[r[10:8]];
      if (i < 32) return {2'b00, i[4:1], i[0], a};
      if (i < 40) return {2'b01, i[1:0], r[2:0], a};
      if (i < 56) return {2'b11, i[3:0], r[7:0]};
      if (i < 58) return {2'b10, i[0], r[10:0]};
      if (i < NDIR) return CTRL[i - 58];
      return {r[13:7], a};
   endfunction

   function automatic logic [7:0] addsub(input logic [7:0] p, input logic [7:0] m, input logic sub);
      if (sub) begin
         c = p >= m;
         hc = p[3:0] >= m[3:0];
         return p - m;
      end
      c = ({1'b0, p} + {1'b0, m}) > 9'h0ff;
      hc = ({1'b0, p[3:0]} + {1'b0, m[3:0]}) > 5'h0f;
      return p + m;
   endfunction

   task automatic model(input mid_pkg::mid_word_t w, input logic [7:0] pins, input logic pot,
                        output mid_exp_t o);
      logic [7:0] f, r;
      logic [6:0] a;
      logic wr, pcl, push, pop, irq, slp, kick, nop, skip;
      a = w[6:0];
      f = (a == PORT) ? pins : mem[a];
      r = acc;
      {wr, pcl, push, pop, irq, slp, kick, nop, skip} = '0;
      if (discard) begin
         nop = 1'b1;
      end else begin
         case (w[13:12])
            2'b00: begin
               case (w[11:8])
                  4'h0: r = acc;
                  4'h1: r = 8'h00;
                  4'h2: r = addsub(f, acc, 1'b1);
                  4'h3, 4'hb: r = f - 8'h01;
                  4'h4: r = acc | f;
                  4'h5: r = acc & f;
                  4'h6: r = acc ^ f;
                  4'h7: r = addsub(acc, f, 1'b0);
                  4'h8: r = f;
                  4'h9: r = ~f;
                  4'ha, 4'hf: r = f + 8'h01;
                  4'hc: {r, c} = {c, f};
                  4'hd: {c, r} = {f, c};
                  default: r = {f[3:0], f[7:4]};
               endcase
               if (w[11:8] <= 4'ha && w[11:8] != 4'h0) z = r == 8'h00;
               skip = (w[11:8] == 4'hb || w[11:8] == 4'hf) && r == 8'h00;
               if (w[7]) wr = 1'b1;
               else if (w[11:8] != 4'h0) acc = r;
               else if (a == 7'h08 || a == 7'h09) {pop, irq, skip} = {1'b1, a[0], 1'b1};
               else if (a == 7'h63 || a == 7'h64) {slp, kick, wx, sl} = {~a[2], a[2], 1'b0, ~a[2]};
            end
            2'b01: begin
               r = f;
               r[w[9:7]] = w[10];
               wr = !w[11];
               skip = w[11] && (f[w[9:7]] == w[10]);
            end
            2'b10: {pcl, push, skip} = {1'b1, !w[11], 1'b1};
            default: begin
               casez (w[11:8])
                  4'b00??, 4'b01??: begin
                     acc = w[7:0];
                     pop = w[10];
                     skip = w[10];
                  end
                  4'b1000: acc = acc | w[7:0];
                  4'b1001: acc = acc & w[7:0];
                  4'b1010: acc = acc ^ w[7:0];
                  4'b110?: acc = addsub(w[7:0], acc, 1'b1);
                  4'b111?: acc = addsub(acc, w[7:0], 1'b0);
                  default: ;
               endcase
               if (w[11] && w[11:8] != 4'hb) z = acc == 8'h00;
            end
         endcase
      end
      discard = skip;
      if (wr) mem[a] = r;
      o.st = {acc, c, hc, z, wx, sl};
      o.io = {wr, wr && a == TMR && pot, wr ? {a, r} : 15'h0000};
      o.fl = {pcl, push, pop, irq, slp, kick, nop, pcl ? w[10:0] : 11'h000};
   endtask

   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_state(input logic [12:0] got, input logic [12:0] exp);
      report({19'h0, got}, {19'h0, exp});
   endtask
   task automatic chk_io(input logic [16:0] got, input logic [16:0] exp);
      report({15'h0, got}, {15'h0, exp});
   endtask
   task automatic chk_flow(input logic [17:0] got, input logic [17:0] exp);
      report({14'h0, got}, {14'h0, exp});
   endtask

   task automatic summarize();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // ====================
   // Driver: one word per fetch, the note goes to the queue as it is handed over
   always @(posedge clk) begin
      if (running && fetchStrobe === 1'b1 && idx < NTOT) begin
         // Pins and prescaler flag stand while the word taken now executes
         tmp = rnd();
         curPins = tmp[7:0];
         curPot = tmp[8];
         model(curWord, curPins, curPot, e);
         q.push_back(e);
         idx++;
         if (idx == NDIR) $display("opcode sweep done");
         curWord = gen(idx);
         instrWord <= curWord;
         portPinData <= curPins;
         prescalerOnTimer <= curPot;
      end
   end

   // Watcher: results settle in the fetch cycle, so look at mid-cycle
   always @(negedge clk) begin
      if (arst_n === 1'b1) begin
         gap++;
         if (fetchStrobe === 1'b1) begin
            if (seenFetch) report(gap, 4);
            seenFetch = 1'b1;
            gap = 0;
            if (q.size() > 0) begin
               x = q.pop_front();
               chk_state(stNow, x.st);
               chk_io({ioNow[16:15], x.io[16] ? ioNow[14:0] : 15'h0}, x.io);
               chk_flow({flNow[17:11], x.fl[17] ? flNow[10:0] : 11'h0}, x.fl);
            end
         end
      end
   end

   // ====================
   // Main sequence
   initial begin
      {acc, c, hc, z, wx, sl, discard, curPot, running, seenFetch} = '0;
      {idx, gap, failures, n_compared} = '0;
      curPins = 8'h00;
      for (int i = 0; i < 128; i++) begin
         init = rnd();
         mem[i] = (i == 34) ? 8'hff : (i == 35) ? 8'h01 : init[7:0];
         mid_file_model_inst.mem[i] = mem[i];
      end
      curWord = gen(0);
      instrWord = curWord;
      repeat (7) @(posedge clk);
      @(negedge clk);
      chk_state(stNow, 13'h0000);
      chk_io(ioNow, 17'h00000);
      chk_flow(flNow, 18'h00800);
      $display("reset values checked");
      @(posedge clk);
      arst_n <= 1'b1;
      running = 1'b1;
      for (int t = 0; t < 15000 && (idx < NTOT || q.size() > 0); t++) @(posedge clk);
      if (idx < NTOT || q.size() > 0) failures++;
      $display("random instruction run done");
      summarize();
   end

   // Bound set well above the roughly 2000 cycles the run needs
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("run timed out");
      summarize();
   end
endmodule
`default_nettype wire

// file: mid_file_model.sv
// Data register file model that answers the decoder's file reads and writes
`timescale 1ns/1ps
`default_nettype none
module mid_file_model #(
   parameter logic [6:0] PORT_ADDR = 7'h06
) (
   // Clock
   input  wire logic       clk,
   // Read side
   input  wire logic [6:0] fileRdAddr,
   output logic      [7:0] fileRdData,
   output logic            fileIsPort,
   // Write side
   input  wire logic       fileWrEn,
   input  wire logic [6:0] fileWrAddr,
   input  wire logic [7:0] fileWrData
);
   // ====================
   // Storage
   logic [7:0] mem [128];

   // A port read hands back the latch, so a decoder that ignores the pins is caught
   assign fileRdData = mem[fileRdAddr];
   assign fileIsPort = fileRdAddr == PORT_ADDR;

   // Plain always: the bench preloads the array at time zero
   always @(posedge clk) begin
      if (fileWrEn === 1'b1) begin
         mem[fileWrAddr] <= fileWrData;
      end
   end
endmodule
`default_nettype wire

// file: mid_pkg.sv
// Types shared by the instruction decoder
`default_nettype none
package mid_pkg;
   typedef enum logic {CYC_EXEC, CYC_NOP} mid_cyc_t;
   typedef logic [13:0] mid_word_t;
endpackage
`default_nettype wire
